//--- hdl/kmse_encoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "kmse_regs.svh"
// Summary of operation
// - serve 4 columns by 4 or 5 rows
// - code is 4 or 5 bits wide
// - rows idle high, columns low in turn
// - 2-bit counter decoded one-hot onto columns
// - row low on driven column freezes scan
// - row low starts debounce, locks other rows
// - code is row index times four plus column count
// - debounce expiry latches code, raises valid
// - early release restarts scan and timer
// - after release wait timeout before new closure
// - second key ignored until first released
// - code outputs driven only while enable low
// - debounce about RC, release about 0.7 RC
// - enable from i_output_enable_n alone, independent of valid
module kmse_encoder #(
  parameter int NUM_ROWS = `KMSE_ROWS_LARGE,
  parameter int SCAN_CYC = `KMSE_SCAN_CYC,
  parameter int MASK_CYC = `KMSE_MASK_CYC,
  parameter int RELEASE_CYC = `KMSE_RELEASE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [NUM_ROWS-1:0] i_row_sense,
  input wire logic i_output_enable_n,
  output logic [`KMSE_NUM_COLS-1:0] o_column_drive_oe,
  output logic [`KMSE_NUM_COLS-1:0] o_column_drive,
  output kmse_pkg::kmse_key_t o_key,
  output logic [4:0] o_code_oe
);
  import kmse_pkg::*;

  localparam int CODE_W = (NUM_ROWS > `KMSE_ROWS_SMALL) ? 5 : 4;

  logic [NUM_ROWS-1:0] row_meta_q;
  logic [NUM_ROWS-1:0] row_sync_q;
  kmse_state_t state_q;
  kmse_state_t state_d;
  logic [1:0] col_q;
  logic [2:0] row_idx_q;
  logic [31:0] scan_cnt_q;
  logic [31:0] tmr_q;
  logic [4:0] code_q;
  logic valid_q;

  // first flop feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      row_meta_q <= '1;
      row_sync_q <= '1;
    end else begin
      row_meta_q <= i_row_sense;
      row_sync_q <= row_meta_q;
    end
  end

  // lowest active row, its index and presence
  logic [2:0] low_idx;
  logic any_low;
  always_comb begin
    low_idx = 3'h0;
    any_low = 1'b0;
    for (int r = NUM_ROWS - 1; r >= 0; r--) begin
      if (!row_sync_q[r]) begin
        low_idx = 3'(r);
        any_low = 1'b1;
      end
    end
  end

  wire scan_tick = (scan_cnt_q == 32'(SCAN_CYC - 1));
  wire locked_low = !row_sync_q[row_idx_q];
  wire tmr_done = (tmr_q == 32'h0);
  wire [4:0] new_code = 5'({row_idx_q, col_q});

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      KMSE_SCAN: begin
        if (any_low) begin
          state_d = KMSE_DEBOUNCE;
        end
      end
      KMSE_DEBOUNCE: begin
        if (!locked_low) begin
          state_d = KMSE_SCAN;
        end else if (tmr_done) begin
          state_d = KMSE_HELD;
        end
      end
      KMSE_HELD: begin
        if (!locked_low) begin
          state_d = KMSE_RELEASE;
        end
      end
      KMSE_RELEASE: begin
        if (locked_low) begin
          state_d = KMSE_HELD;
        end else if (tmr_done) begin
          state_d = KMSE_SCAN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scan_cnt_q <= 32'h0;
      col_q <= 2'h0;
    end else if (state_q == KMSE_SCAN && !any_low) begin
      scan_cnt_q <= scan_tick ? 32'h0 : scan_cnt_q + 32'h1;
      if (scan_tick) begin
        col_q <= col_q + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= KMSE_SCAN;
      row_idx_q <= 3'h0;
      tmr_q <= 32'h0;
    end else begin
      state_q <= state_d;
      if (state_q == KMSE_SCAN && any_low) begin
        row_idx_q <= low_idx;
        tmr_q <= 32'(MASK_CYC - 1);
      end else if (state_q == KMSE_HELD && !locked_low) begin
        tmr_q <= 32'(RELEASE_CYC - 1);
      end else if (state_q == KMSE_RELEASE && locked_low) begin
        tmr_q <= 32'h0;
      end else if (!tmr_done) begin
        tmr_q <= tmr_q - 32'h1;
      end
    end
  end

  // output register and valid flag
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      code_q <= 5'h0;
      valid_q <= 1'b0;
    end else begin
      if (state_q == KMSE_DEBOUNCE && locked_low && tmr_done) begin
        code_q <= new_code;
        valid_q <= 1'b1;
      end else if (state_q == KMSE_HELD && !locked_low) begin
        valid_q <= 1'b0;
      end
    end
  end

  // one-hot open-drain column drive, held while a key is tracked
  genvar c;
  generate
    for (c = 0; c < `KMSE_NUM_COLS; c++) begin : g_col
      assign o_column_drive[c] = 1'b0;
      assign o_column_drive_oe[c] = (col_q == 2'(c));
    end
  endgenerate

  wire code_en = !i_output_enable_n;
  assign o_key.key_valid_flag = valid_q;
  assign o_key.code = code_q & 5'((1 << CODE_W) - 1);
  assign o_code_oe = {5{code_en}} & 5'((1 << CODE_W) - 1);
endmodule
`default_nettype wire

//--- common/kmse_regs.svh
`ifndef KMSE_REGS_SVH
`define KMSE_REGS_SVH
`define KMSE_CLK_HZ 125000000
`define KMSE_NUM_COLS 4
`define KMSE_ROWS_SMALL 4
`define KMSE_ROWS_LARGE 5
`define KMSE_SCAN_HZ 10000
`define KMSE_SCAN_CYC (`KMSE_CLK_HZ / `KMSE_SCAN_HZ)
`define KMSE_MASK_R_OHM 10000
`define KMSE_MASK_C_NF 100
`define KMSE_MASK_T_NS (`KMSE_MASK_R_OHM * `KMSE_MASK_C_NF / 1000 * 1000)
`define KMSE_MASK_CYC (`KMSE_MASK_T_NS / 8)
`define KMSE_RELEASE_CYC (`KMSE_MASK_CYC * 7 / 10)
`endif

//--- common/kmse_pkg.sv
package kmse_pkg;
  typedef enum logic [1:0] {
    KMSE_SCAN = 2'b00,
    KMSE_DEBOUNCE = 2'b01,
    KMSE_HELD = 2'b10,
    KMSE_RELEASE = 2'b11
  } kmse_state_t;
  typedef struct packed {
    logic key_valid_flag;
    logic [4:0] code;
  } kmse_key_t;
endpackage

//--- verification/kmse_key_matrix.sv
`timescale 1ns/1ps
`default_nettype none
module kmse_key_matrix (
  input wire logic [3:0] i_col_oe,
  input wire logic [19:0] i_keys,
  output logic [4:0] o_row
);
  always_comb begin
    for (int r = 0; r < 5; r++) begin
      o_row[r] = ~|(i_keys[r*4+:4] & i_col_oe);
    end
  end
endmodule
`default_nettype wire

//--- verification/kmse_encoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module kmse_encoder_asserts #(
  parameter int NUM_ROWS = 5,
  parameter int MASK_CYC = 20
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [NUM_ROWS-1:0] i_row_sense,
  input wire logic i_output_enable_n,
  input wire logic [3:0] o_column_drive_oe,
  input wire logic [3:0] o_column_drive,
  input wire kmse_pkg::kmse_key_t o_key,
  input wire logic [4:0] o_code_oe
);
  import kmse_pkg::*;
  wire logic v = o_key.key_valid_flag;
  wire logic [4:0] en = (NUM_ROWS > 4) ? 5'h1F : 5'h0F;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_col_one_hot: assert property ($onehot(o_column_drive_oe))
    else $error("column enable not one-hot");
  a_col_drive_low: assert property (o_column_drive == 4'h0)
    else $error("column level not low");
  a_code_oe_gate: assert property (o_code_oe == (en & {5{!i_output_enable_n}}))
    else $error("code enable wrong");
  a_scan_frozen: assert property (v && $past(v) |-> $stable(o_column_drive_oe))
    else $error("scan moved while key held");
  a_valid_after_mask: assert property ($rose(v) |-> $past(!(&i_row_sense), MASK_CYC))
    else $error("valid without full debounce");
  a_valid_drop: assert property ((&i_row_sense)[*4] |-> !v)
    else $error("valid kept after release");
  a_release_gap: assert property ($fell(v) |=> !v[*8])
    else $error("new key inside release gap");
  a_code_kept: assert property (!$rose(v) |-> $stable(o_key.code))
    else $error("code changed without acceptance");
  a_code_column: assert property ($rose(v) |-> o_column_drive_oe[o_key.code[1:0]])
    else $error("code column mismatch");
  c_accept: cover property ($rose(v));
  c_release: cover property ($fell(v));
  c_enabled: cover property (o_code_oe != 5'h00);
endmodule
`default_nettype wire

//--- verification/key_matrix_scan_encoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module key_matrix_scan_encoder_bench;
  import kmse_pkg::*;
  logic i_clk = 0, i_rst_n = 0, oe_n = 1;
  logic [19:0] keys = 20'h00000;
  logic [4:0] rows, code_oe;
  logic [3:0] cd_oe, cd;
  kmse_key_t key;
  int bad_count = 0, n_tests = 0;
  always #4 i_clk = ~i_clk;
  // scan rate is shortened for run time; a host scan clock runs at 10 kHz
  kmse_encoder #(.NUM_ROWS(5), .SCAN_CYC(4), .MASK_CYC(20), .RELEASE_CYC(14)) uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_row_sense(rows), .i_output_enable_n(oe_n),
    .o_column_drive_oe(cd_oe), .o_column_drive(cd), .o_key(key), .o_code_oe(code_oe));
  kmse_key_matrix pm (.i_col_oe(cd_oe), .i_keys(keys), .o_row(rows));
  task chk(input logic [4:0] s, input logic [4:0] e, input string nm);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wv(input logic v);
    int n;
    n = 0;
    @(negedge i_clk);
    while (key.key_valid_flag !== v && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    chk({4'h0, key.key_valid_flag}, {4'h0, v}, "valid");
  endtask
  task press(input int k, input logic [19:0] m);
    @(posedge i_clk);
    keys <= m;
    if (k >= 0) begin
      wv(1);
      chk(key.code, 5'(k), "code");
    end
  endtask
  task t_keys;
    for (int k = 0; k < 20; k++) begin
      press(k, 20'h1 << k);
      press(-1, 20'h0);
      wv(0);
    end
    $display("t_keys done");
  endtask
  task t_bounce;
    repeat (40) @(posedge i_clk);
    press(-1, 20'h1 << 5);
    repeat (8) @(posedge i_clk);
    press(-1, 20'h0);
    repeat (40) @(posedge i_clk);
    chk({4'h0, key.key_valid_flag}, 5'h00, "bounce");
    chk(key.code, 5'd19, "kept");
    $display("t_bounce done");
  endtask
  task t_roll;
    press(2, 20'h4);
    press(-1, 20'h204);
    repeat (40) @(posedge i_clk);
    chk(key.code, 5'd2, "second ignored");
    press(-1, 20'h200);
    wv(0);
    chk(key.code, 5'd2, "held code");
    wv(1);
    chk(key.code, 5'd9, "roll over");
    $display("t_roll done");
  endtask
  task t_oe;
    @(posedge i_clk);
    oe_n <= 0;
    @(negedge i_clk);
    chk(code_oe, 5'h1F, "oe on");
    @(posedge i_clk);
    oe_n <= 1;
    @(negedge i_clk);
    chk(code_oe, 5'h00, "oe off");
    press(-1, 20'h0);
    wv(0);
    $display("t_oe done");
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1;
    t_keys;
    t_bounce;
    t_roll;
    t_oe;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    tally_and_finish;
  end
endmodule
bind kmse_encoder kmse_encoder_asserts #(.NUM_ROWS(NUM_ROWS), .MASK_CYC(MASK_CYC)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_row_sense(i_row_sense),
  .i_output_enable_n(i_output_enable_n), .o_column_drive_oe(o_column_drive_oe),
  .o_column_drive(o_column_drive), .o_key(o_key), .o_code_oe(o_code_oe));
`default_nettype wire
